/* File: common/mgmt_framer_defines.svh */
// offsets, field positions and sizes of the management message framer
`ifndef MGMT_FRAMER_DEFINES_SVH
`define MGMT_FRAMER_DEFINES_SVH
`define REQ_OCT_CTRL      4'h0
`define REQ_OCT_ADDR_LAST 4'h6
`define REQ_OCT_LEN_HI    4'h7
`define REQ_OCT_LEN_LO    4'h8
`define REQ_OCT_TXN_HI    4'h9
`define REQ_OCT_TXN_LO    4'hA
`define CONF_OCT_CTRL     3'h0
`define CONF_OCT_LEN_HI   3'h1
`define CONF_OCT_LEN_LO   3'h2
`define CONF_OCT_TXN_HI   3'h3
`define CONF_OCT_TXN_LO   3'h4
`define CONF_OCT_BODY     3'h5
`define CTRL_KIND_MASK    8'h0F
`define KIND_FIRST_IF     4'h0
`define KIND_MODEL_LO     4'h1
`define KIND_MODEL_HI     4'h4
`define KIND_SIXTH_IF     4'h5
`define FIFO_WIDTH        8
`define FIFO_DEPTH        8
`define FIFO_CNT_W        4
`define FIFO_ROOM_MAX     4'h6
`endif

/* File: common/mgmt_framer_pkg.sv */
// types of the management message framer
package mgmt_framer_pkg;
  typedef enum logic [0:0] {PH_REQ_HDR, PH_CONF} phase_t;

  typedef struct packed {
    phase_t      ph;
    logic [3:0]  idx;
    logic [7:0]  ctrl;
    logic [47:0] addr;
    logic [15:0] len;
    logic [15:0] txn;
    logic        is_ctrl;
    logic [15:0] rx_left;
    logic [15:0] tx_left;
    logic [2:0]  hdr_idx;
    logic [2:0]  oidx;
    logic        out_valid;
    logic [7:0]  out_data;
    logic        out_last;
    logic        out_ctrl;
    logic        in_ready;
    logic        hdr_pulse;
    logic [15:0] body_cnt;
    logic        kind_rsvd;
  } state_t;
endpackage

/* File: hdl/byte_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             push_valid_in,
  output logic                  push_ready_out,
  input  wire logic [WIDTH-1:0] push_data_in,
  output logic                  pop_valid_out,
  input  wire logic             pop_ready_in,
  output logic [WIDTH-1:0]      pop_data_out,
  output logic [CNT_W-1:0]      count_out
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CNT_W-1:0]            cnt;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic        push;
  logic        pop;

  assign push_ready_out = (q.cnt != CNT_W'(DEPTH));
  assign pop_valid_out  = (q.cnt != '0);
  assign pop_data_out   = q.mem[q.rd];
  assign count_out      = q.cnt;

  always_comb begin
    d    = q;
    push = push_valid_in && push_ready_out;
    pop  = pop_ready_in && pop_valid_out;
    if (push) begin
      d.mem[q.wr] = push_data_in;
      d.wr        = (q.wr == PW'(DEPTH - 1)) ? '0 : PW'(q.wr + 1'b1);
    end
    if (pop) begin
      d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : PW'(q.rd + 1'b1);
    end
    d.cnt = CNT_W'(q.cnt + {{(CNT_W-1){1'b0}}, push} - {{(CNT_W-1){1'b0}}, pop});
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  fifo_no_overflow_a: assert property (q.cnt <= CNT_W'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

/* File: hdl/mgmt_write_ctrl_msg_framer.sv */
// parser of write/control requests and builder of their confirmations
// Summary of operation
// R1: the partner sends write requests, unicast or multicast, to this node.
// R2: request octet 0 is control, octets 1 to 6 the requester address.
// R3: a node-originated request carries its registration identifier as address.
// R4: request octets 7 and 8 give the value payload length in bytes.
// R5: request octets 9 and 10 give the transaction id; payload follows.
// R6: the value payload has variable length, meaning set by the request kind.
// R7: the node answers a write request with a unicast write confirmation.
// R8: confirmation: control, length in 1-2, transaction id in 3-4, payload.
// R9: confirmations hold no requester address; length follows control directly.
// R10: control-action requests use the same layout as write requests.
// R11: the node answers a control-action request with a control confirmation.
// R12: control bits 3:0 give the request kind; 0 and 5 defined, rest reserved.
// R13: reserved control bits 7:4 are sent as zero and ignored on receipt.
// R14: the requester counts transaction ids from zero, wrapping after the maximum.
// R15: every accepted request gets its matching confirmation; length counts payload.
// R16: multi-octet fields travel most significant octet first.
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_framer_defines.svh"
module mgmt_write_ctrl_msg_framer (
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic        req_valid_in,
  input  wire logic [7:0]  req_data_in,
  input  wire logic        req_is_control_in,
  output logic             req_ready_out,
  output logic             conf_valid_out,
  output logic [7:0]       conf_data_out,
  output logic             conf_last_out,
  output logic             conf_is_control_out,
  input  wire logic        conf_ready_in,
  output logic             req_hdr_valid_out,
  output logic [47:0]      requester_address_out,
  output logic [3:0]       request_kind_out,
  output logic             kind_reserved_out,
  output logic [15:0]      value_length_out,
  output logic [15:0]      transaction_id_out
);
  mgmt_framer_pkg::state_t q;
  mgmt_framer_pkg::state_t d;
  logic                    rst_meta_q;
  logic                    rst_n;
  logic                    acc;
  logic                    ld;
  logic                    push;
  logic                    pop;
  logic                    fifo_push_ready;
  logic                    fifo_pop_valid;
  logic [7:0]              fifo_data;
  logic [`FIFO_CNT_W-1:0]  fifo_count;

  function automatic logic [15:0] shift16(input logic [15:0] old, input logic [7:0] b);
    shift16 = {old[7:0], b};
  endfunction

  function automatic logic is_reserved(input logic [7:0] c);
    is_reserved = (c[3:0] != `KIND_FIRST_IF) && (c[3:0] != `KIND_SIXTH_IF);
  endfunction

  // reset enters asynchronously, leaves synchronously
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .CNT_W (`FIFO_CNT_W)
  ) u_payload_fifo (
    .clk_in         (mclk_in),
    .rst_n_in       (rst_n),
    .push_valid_in  (push),
    .push_ready_out (fifo_push_ready),
    .push_data_in   (req_data_in),
    .pop_valid_out  (fifo_pop_valid),
    .pop_ready_in   (pop),
    .pop_data_out   (fifo_data),
    .count_out      (fifo_count)
  );

  always_comb begin
    d           = q;
    d.hdr_pulse = 1'b0;
    acc         = req_valid_in && q.in_ready;
    ld          = !q.out_valid || conf_ready_in;
    push        = acc && (q.ph == mgmt_framer_pkg::PH_CONF);
    pop         = fifo_pop_valid && ld && (q.ph == mgmt_framer_pkg::PH_CONF) &&
                  (q.hdr_idx == `CONF_OCT_BODY) && (q.tx_left != 16'h0000);
    unique case (q.ph)
      mgmt_framer_pkg::PH_REQ_HDR: begin
        // the last confirmation byte may still stand here; drop it once taken
        if (conf_ready_in) begin
          d.out_valid = 1'b0;
          d.out_last  = 1'b0;
        end
        if (acc) begin
          d.idx = 4'(q.idx + 4'h1);
          if (q.idx == `REQ_OCT_CTRL) begin
            d.ctrl    = req_data_in & `CTRL_KIND_MASK; // R13
            d.is_ctrl = req_is_control_in; // R10
          end else if (q.idx <= `REQ_OCT_ADDR_LAST) begin
            d.addr = {q.addr[39:0], req_data_in}; // R2 R3 R16
          end else if (q.idx <= `REQ_OCT_LEN_LO) begin
            d.len = shift16(q.len, req_data_in); // R4 R16
          end else begin
            d.txn = shift16(q.txn, req_data_in); // R5 R16
          end
          if (q.idx == `REQ_OCT_TXN_LO) begin
            d.ph        = mgmt_framer_pkg::PH_CONF; // R15
            d.idx       = 4'h0;
            d.hdr_idx   = `CONF_OCT_CTRL;
            d.rx_left   = q.len; // R15
            d.tx_left   = q.len;
            d.body_cnt  = 16'h0000;
            d.hdr_pulse = 1'b1;
          end
        end
      end
      mgmt_framer_pkg::PH_CONF: begin
        if (push) begin
          d.rx_left = q.rx_left - 16'h0001; // R6
        end
        if (ld) begin
          d.out_valid = 1'b0;
          d.out_last  = 1'b0;
          if (q.hdr_idx != `CONF_OCT_BODY) begin
            // no address field: length sits right after the control octet
            unique case (q.hdr_idx)
              `CONF_OCT_CTRL:   d.out_data = q.ctrl; // R8 R13
              `CONF_OCT_LEN_HI: d.out_data = q.len[15:8]; // R9 R16
              `CONF_OCT_LEN_LO: d.out_data = q.len[7:0];
              `CONF_OCT_TXN_HI: d.out_data = q.txn[15:8]; // R8
              default:          d.out_data = q.txn[7:0];
            endcase
            d.out_valid = 1'b1;
            d.oidx      = q.hdr_idx;
            d.out_ctrl  = q.is_ctrl; // R7 R11
            d.out_last  = (q.hdr_idx == `CONF_OCT_TXN_LO) && (q.len == 16'h0000);
            d.hdr_idx   = 3'(q.hdr_idx + 3'h1);
          end else if (pop) begin
            d.out_valid = 1'b1;
            d.out_data  = fifo_data; // R6
            d.oidx      = `CONF_OCT_BODY;
            d.tx_left   = q.tx_left - 16'h0001;
            d.body_cnt  = q.body_cnt + 16'h0001;
            d.out_last  = (q.tx_left == 16'h0001); // R15
          end
          if (d.out_last) begin
            d.ph = mgmt_framer_pkg::PH_REQ_HDR;
          end
        end
      end
    endcase
    d.kind_rsvd = is_reserved(d.ctrl); // R12
    // registered ready looks one cycle ahead, so the byte taken in that cycle fills the last fifo slot
    d.in_ready = (d.ph == mgmt_framer_pkg::PH_REQ_HDR) ||
                 ((d.rx_left != 16'h0000) && (fifo_count <= `FIFO_ROOM_MAX));
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign req_ready_out         = q.in_ready;
  assign conf_valid_out        = q.out_valid;
  assign conf_data_out         = q.out_data;
  assign conf_last_out         = q.out_last;
  assign conf_is_control_out   = q.out_ctrl;
  assign req_hdr_valid_out     = q.hdr_pulse;
  assign requester_address_out = q.addr;
  assign request_kind_out      = q.ctrl[3:0]; // R12
  assign kind_reserved_out     = q.kind_rsvd; // R12
  assign value_length_out      = q.len;
  assign transaction_id_out    = q.txn; // R14

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  ctrl_rsvd_zero_a: assert property ( // R13
    conf_valid_out && (q.oidx == `CONF_OCT_CTRL) |-> conf_data_out[7:4] == 4'h0)
    else $error("reserved control bits not zero");
  len_after_ctrl_a: assert property ( // R9
    conf_valid_out && (q.oidx == `CONF_OCT_LEN_HI) |-> conf_data_out == value_length_out[15:8])
    else $error("length high octet misplaced");
  txn_echo_a: assert property ( // R8
    conf_valid_out && (q.oidx == `CONF_OCT_TXN_LO) |-> conf_data_out == transaction_id_out[7:0])
    else $error("transaction id low octet wrong");
  conf_start_a: assert property ( // R7
    req_hdr_valid_out && !conf_valid_out |=> conf_valid_out && (q.oidx == `CONF_OCT_CTRL))
    else $error("confirmation did not start");
  kind_match_a: assert property ( // R11
    req_hdr_valid_out && !conf_valid_out |=> conf_is_control_out == $past(q.is_ctrl))
    else $error("confirmation kind mismatch");
  payload_count_a: assert property ( // R15
    conf_valid_out && conf_last_out |-> (q.oidx == `CONF_OCT_BODY) ? (q.body_cnt == q.len) : (q.len == 16'h0000))
    else $error("payload count differs from length");
  txn_lsb_last_a: assert property ( // R16
    req_hdr_valid_out |-> transaction_id_out[7:0] == $past(req_data_in))
    else $error("transaction id octet order wrong");
  conf_hold_a: assert property ( // R6
    conf_valid_out && !conf_ready_in |=> conf_valid_out && $stable(conf_data_out) && $stable(conf_last_out))
    else $error("confirmation byte dropped under stall");
  push_room_a: assert property ( // R6
    push |-> fifo_push_ready)
    else $error("payload pushed into full fifo");
  no_extra_input_a: assert property ( // R15
    (q.ph == mgmt_framer_pkg::PH_CONF) && (q.rx_left == 16'h0000) |-> !req_ready_out)
    else $error("input taken beyond payload length");

  write_conf_c: cover property (conf_valid_out && conf_last_out && conf_ready_in && !conf_is_control_out);
  ctrl_conf_c: cover property (conf_valid_out && conf_last_out && conf_ready_in && conf_is_control_out);
  empty_payload_c: cover property (req_hdr_valid_out && value_length_out == 16'h0000);
  fifo_backpressure_c: cover property (q.ph == mgmt_framer_pkg::PH_CONF && q.rx_left != 16'h0000 && !req_ready_out);
endmodule
`default_nettype wire

/* File: sim/app_entity_model.sv */
// behavioural application entity: request source and confirmation sink
`timescale 1ns/1ps
`default_nettype none
module app_entity_model (
  input  wire logic       clk_in,
  input  wire logic       stall_in,
  input  wire logic       req_ready_in,
  output logic            req_valid_out,
  output logic [7:0]      req_data_out,
  output logic            req_is_control_out,
  output logic            conf_ready_out
);
  logic [8:0]  q[$];
  logic [15:0] txn_q = 16'h0000;
  task automatic set_txn(input logic [15:0] v);
    txn_q = v;
  endtask
  // octet0 may carry nonzero upper bits only when a scenario asks for it
  task automatic queue_req(input logic ctl, input logic [7:0] octet0, input logic [47:0] addr,
                           input logic [15:0] len, output logic [15:0] txn);
    txn = txn_q;
    txn_q = txn_q + 16'h0001;
    q.push_back({ctl, octet0});
    for (int i = 5; i >= 0; i--) q.push_back({ctl, addr[i*8+:8]});
    q.push_back({ctl, len[15:8]});
    q.push_back({ctl, len[7:0]});
    q.push_back({ctl, txn[15:8]});
    q.push_back({ctl, txn[7:0]});
    for (int i = 0; i < len; i++) q.push_back({ctl, addr[7:0] + i[7:0]});
  endtask
  initial begin
    req_valid_out = 1'b0;
    req_data_out = 8'h00;
    req_is_control_out = 1'b0;
    conf_ready_out = 1'b0;
  end
  // idle data inverts every cycle so a stale byte never looks valid
  always @(posedge clk_in) begin
    if (req_valid_out && req_ready_in) void'(q.pop_front());
    req_valid_out <= q.size() != 0;
    if (q.size() != 0) {req_is_control_out, req_data_out} <= q[0];
    else req_data_out <= ~req_data_out;
    conf_ready_out <= !stall_in;
  end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the management message framer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk_in, arst_n_in, stall, req_valid, req_is_control, req_ready, conf_ready;
  logic [7:0]  req_data, conf_data_out;
  logic        conf_valid_out, conf_last_out, conf_is_control_out, req_hdr_valid_out, kind_reserved_out;
  logic [47:0] requester_address_out;
  logic [3:0]  request_kind_out;
  logic [15:0] value_length_out, transaction_id_out;
  logic [9:0]  cq[$], xq[$];
  int          n_mismatch = 0, n_checks = 0, n_last = 0;
  mgmt_write_ctrl_msg_framer dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid),
    .req_data_in(req_data), .req_is_control_in(req_is_control), .req_ready_out(req_ready),
    .conf_valid_out(conf_valid_out), .conf_data_out(conf_data_out), .conf_last_out(conf_last_out),
    .conf_is_control_out(conf_is_control_out), .conf_ready_in(conf_ready),
    .req_hdr_valid_out(req_hdr_valid_out), .requester_address_out(requester_address_out),
    .request_kind_out(request_kind_out), .kind_reserved_out(kind_reserved_out),
    .value_length_out(value_length_out), .transaction_id_out(transaction_id_out));
  app_entity_model ae (.clk_in(mclk_in), .stall_in(stall), .req_ready_in(req_ready), .req_valid_out(req_valid),
    .req_data_out(req_data), .req_is_control_out(req_is_control), .conf_ready_out(conf_ready));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (conf_valid_out && conf_ready) begin
      cq.push_back({conf_is_control_out, conf_last_out, conf_data_out});
      n_last += int'(conf_last_out);
    end
  end
  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic give_up(input string what);
    check(what, 48'h1, 48'h0);
    wrap_up();
  endtask
  // expected confirmation: no address field, length right after control
  task automatic send(input logic ctl, input logic [3:0] kind, input logic [3:0] junk,
                      input logic [47:0] addr, input logic [15:0] len, output logic [15:0] txn);
    ae.queue_req(ctl, {junk, kind}, addr, len, txn);
    xq.push_back({ctl, 1'b0, 4'h0, kind});
    xq.push_back({ctl, 1'b0, len[15:8]});
    xq.push_back({ctl, 1'b0, len[7:0]});
    xq.push_back({ctl, 1'b0, txn[15:8]});
    xq.push_back({ctl, 1'b0, txn[7:0]});
    for (int i = 0; i < len; i++) xq.push_back({ctl, 1'b0, addr[7:0] + i[7:0]});
    xq[xq.size()-1][8] = 1'b1;
  endtask
  task automatic header(input logic [3:0] kind, input logic [47:0] addr, input logic [15:0] len,
                        input logic [15:0] txn);
    int n;
    n = 0;
    while (req_hdr_valid_out !== 1'b1) begin
      @(posedge mclk_in);
      #1;
      n++;
      if (n > 400) give_up("header_pulse");
    end
    check("address", addr, requester_address_out);
    check("kind", 48'(kind), 48'(request_kind_out));
    check("reserved", 48'(kind != 4'h0 && kind != 4'h5), 48'(kind_reserved_out));
    check("length", 48'(len), 48'(value_length_out));
    check("txn", 48'(txn), 48'(transaction_id_out));
  endtask
  task automatic drain(input int nmsg);
    int n;
    n = 0;
    while (n_last < nmsg) begin
      @(posedge mclk_in);
      #1;
      n++;
      if (n > 2000) give_up("confirm_last");
    end
    check("conf_count", 48'(xq.size()), 48'(cq.size()));
    check("conf_idle", 48'h0, 48'(conf_valid_out));
    foreach (xq[i]) check("conf_byte", 48'(xq[i]), 48'(cq[i]));
    cq.delete();
    xq.delete();
    n_last = 0;
  endtask
  task automatic do_req(input logic ctl, input logic [3:0] kind, input logic [3:0] junk,
                        input logic [47:0] addr, input logic [15:0] len);
    logic [15:0] txn;
    send(ctl, kind, junk, addr, len, txn);
    header(kind, addr, len, txn);
    drain(1);
  endtask
  task automatic t_write_one;
    do_req(1'b0, 4'h0, 4'h0, 48'h0A1B2C3D4E5F, 16'h0001);
  endtask
  // node-originated request with junk in the reserved control bits
  task automatic t_ctrl_registration_identifier;
    do_req(1'b1, 4'h5, 4'hA, 48'h00000000002A, 16'h0000);
  endtask
  task automatic t_all_kinds;
    for (int k = 0; k < 16; k++) do_req(k[0], k[3:0], 4'h0, 48'hC0FFEE001100 + 48'(k), 16'(k));
  endtask
  // sink stalls so the buffer fills and the request side must be refused
  task automatic t_fifo_stall;
    logic [15:0] txn;
    @(posedge mclk_in);
    stall <= 1'b1;
    send(1'b0, 4'h5, 4'h0, 48'h123456789ABC, 16'h0014, txn);
    header(4'h5, 48'h123456789ABC, 16'h0014, txn);
    repeat (40) @(posedge mclk_in);
    #1;
    check("ready_full", 48'h0, 48'(req_ready));
    check("valid_held", 48'h1, 48'(conf_valid_out));
    @(posedge mclk_in);
    stall <= 1'b0;
    drain(1);
  endtask
  // two requests back to back across the identifier wrap
  task automatic t_back_to_back;
    logic [15:0] t1, t2;
    ae.set_txn(16'hFFFF);
    send(1'b0, 4'h5, 4'h0, 48'h665544332211, 16'h0002, t1);
    send(1'b1, 4'h0, 4'h0, 48'h010203040506, 16'h0003, t2);
    drain(2);
  endtask
  initial begin
    arst_n_in = 1'b0;
    stall = 1'b0;
    repeat (12) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    t_write_one();
    t_ctrl_registration_identifier();
    t_all_kinds();
    t_fifo_stall();
    t_back_to_back();
    wrap_up();
  end
endmodule
`default_nettype wire
